// File: logic/csbic_pkg.sv
// package: register map, field positions and types of the status/mono control block
package csbic_pkg;
    // register offsets
    localparam logic [7:0] ADDR_MONO_CTRL = 8'h01;
    localparam logic [7:0] ADDR_IRQ_STAT  = 8'h04;
    localparam logic [7:0] ADDR_IRQ_MASK  = 8'h05;
    localparam logic [7:0] ADDR_COPY_CTRL = 8'h07;
    localparam logic [7:0] ADDR_BUF_FIRST = 8'h08;
    localparam logic [7:0] ADDR_BUF_LAST  = 8'h37;
    localparam int         BUF_BYTES      = 48;
    localparam logic [5:0] BUF_LAST_IDX   = 6'h2F;
    // mono control fields
    localparam int MONO_EN_BIT  = 0;
    localparam int MONO_SRC_BIT = 1;
    localparam int MONO_CS_BIT  = 2;
    // status / mask fields
    localparam int FLAG_COPY_DONE = 0;
    localparam int FLAG_SLIP_BLK  = 1;
    localparam int FLAG_AUX       = 2;
    localparam int MASK_SLIP_BLOCKSTART_SELECT_BIT  = 7;
    // copy control field
    localparam int COPY_DIS_BIT = 0;
    // reset values
    localparam logic [7:0] RST_MONO_CTRL = 8'h00;
    localparam logic [7:0] RST_IRQ_MASK  = 8'h00;
    localparam logic [7:0] RST_COPY_CTRL = 8'h00;
    localparam logic [7:0] RST_IRQ_STAT  = 8'h00;
    // frames of a block in which the buffer copy may start
    localparam logic [7:0] COPY_FRAME_FIRST = 8'hB8;
    localparam logic [7:0] COPY_FRAME_LAST  = 8'hBF;
    localparam int         SAMPLE_W         = 24;

    typedef enum logic {CSBIC_IDLE, CSBIC_COPY} csbic_state_t;

    // one decoded control-port access
    typedef struct packed {
        logic [7:0] addr;
        logic       wr;
        logic       rd;
        logic [7:0] wdata;
    } csbic_req_t;

    // one pair of transmitted subframes
    typedef struct packed {
        logic [SAMPLE_W-1:0] sub_a;
        logic [SAMPLE_W-1:0] sub_b;
    } csbic_frame_t;
endpackage : csbic_pkg

// File: logic/csbic_top.sv
// module: channel-status copy, interrupt flags and mono source selection
//
// Functional notes
// - copy-disable rests at zero; host sets it while rewriting the host buffer
// - buffer copy only starts in frames 184 through 191 of a block
// - after copy-disable clears, copy runs in the first eligible frame
// - finished copy sets copy-done flag and, if unmasked, the interrupt
// - host buffer reads and writes are discarded while a copy runs
// - setting copy-disable during a copy aborts it
// - three interrupt conditions, generated only under software control
// - interrupt pin driven low on unmasked flag, otherwise released
// - flags and interrupt hold until status read; read clears all but flags set in the read cycle
// - each flag active high and sticky until status read
// - mask register bit set disables that flag's interrupt
// - select bit picks slip (0) or block start (1) for shared flag
// - slip mode sets shared flag on each dropped or repeated sample
// - block-start mode sets shared flag on internal or external block start
// - mono mode sends two consecutive samples of one channel in A and B
// - software mode: control register selects mono, audio and status source
// - hardware mode: mono pin low stereo, high mono
// - source low: left audio, status A; high: right audio, status B
`timescale 1ns/1ps
module csbic_top
    import csbic_pkg::*;
(
    // clock and reset
    input  wire logic                clk,
    input  wire logic                srst,
    // control port access and mode strap
    input  wire csbic_req_t          req,
    output logic [7:0]               rdata,
    input  wire logic                sw_mode,
    // hardware-mode pins
    input  wire logic                mono_pin,
    input  wire logic                source_pin,
    // frame timing and events from the encoder
    input  wire logic                frame_start,
    input  wire logic [7:0]          frame_num,
    input  wire logic                slip_event,
    input  wire logic                block_start_int,
    input  wire logic                block_start_io,
    input  wire logic                aux_event,
    // transmit-side buffer read port
    input  wire logic [5:0]          tx_cs_addr,
    output logic [7:0]               tx_cs_data,
    // audio samples in, subframes out
    input  wire logic                sample_valid,
    input  wire logic [SAMPLE_W-1:0] left_sample,
    input  wire logic [SAMPLE_W-1:0] right_sample,
    output csbic_frame_t             frame_out,
    output logic                     frame_valid,
    // mono selection state
    output logic                     mono_active,
    output logic                     audio_right,
    output logic                     cs_chan_b,
    // open-drain interrupt, active low
    output logic                     int_n_out,
    output logic                     int_n_oe
);
    logic [7:0]   mono_ctrl;
    logic [7:0]   irq_mask;
    logic [7:0]   copy_ctrl;
    logic [7:0]   irq_stat;
    logic [7:0]   host_buf [BUF_BYTES];
    logic [7:0]   tx_buf   [BUF_BYTES];
    csbic_state_t state;
    logic [5:0]   copy_idx;
    logic         copy_pending;
    logic         dis_q;
    logic         half;
    logic [SAMPLE_W-1:0] first_sample;

    logic       copy_dis;
    logic       in_window;
    logic       buf_hit;
    logic [5:0] buf_idx;
    logic       copy_end;
    logic       stat_read;
    logic       shared_evt;
    logic [7:0] next_events;
    logic       sel_right;
    logic [SAMPLE_W-1:0] sel_sample;

    // decode and event collection
    assign copy_dis   = copy_ctrl[COPY_DIS_BIT];
    assign in_window  = (frame_num >= COPY_FRAME_FIRST) && (frame_num <= COPY_FRAME_LAST);
    assign buf_hit    = (req.addr >= ADDR_BUF_FIRST) && (req.addr <= ADDR_BUF_LAST);
    assign buf_idx    = 6'(req.addr - ADDR_BUF_FIRST);
    assign copy_end   = (state == CSBIC_COPY) && !copy_dis && (copy_idx == BUF_LAST_IDX);
    assign stat_read  = req.rd && (req.addr == ADDR_IRQ_STAT);
    assign shared_evt = irq_mask[MASK_SLIP_BLOCKSTART_SELECT_BIT]
                        ? (block_start_int || block_start_io)
                        : slip_event;
    always_comb
    begin
        next_events                 = 8'h00;
        next_events[FLAG_COPY_DONE] = copy_end;
        next_events[FLAG_SLIP_BLK]  = shared_evt;
        next_events[FLAG_AUX]       = aux_event;
        if (!sw_mode)
            next_events = 8'h00;
    end

    // control registers written by the host
    always_ff @(posedge clk)
    begin
        if (srst)
        begin
            mono_ctrl <= RST_MONO_CTRL;
            irq_mask  <= RST_IRQ_MASK;
            copy_ctrl <= RST_COPY_CTRL;
        end
        else if (req.wr)
        begin
            unique case (req.addr)
                ADDR_MONO_CTRL: mono_ctrl <= req.wdata;
                ADDR_IRQ_MASK:  irq_mask  <= req.wdata;
                ADDR_COPY_CTRL: copy_ctrl <= req.wdata;
                default:        ;
            endcase
        end
    end

    // sticky status flags, cleared by read, set wins
    always_ff @(posedge clk)
    begin
        if (srst)
            irq_stat <= RST_IRQ_STAT;
        else if (stat_read)
            irq_stat <= next_events;
        else
            irq_stat <= irq_stat | next_events;
    end

    // open-drain interrupt: pull low or release
    assign int_n_out = 1'b0;
    assign int_n_oe  = sw_mode && ((irq_stat & ~irq_mask & 8'h07) != 8'h00);

    // copy request remembered from the clearing of copy-disable
    always_ff @(posedge clk)
    begin
        if (srst)
        begin
            dis_q        <= 1'b0;
            copy_pending <= 1'b0;
        end
        else
        begin
            dis_q <= copy_dis;
            if (dis_q && !copy_dis)
                copy_pending <= 1'b1;
            else if (state == CSBIC_COPY)
                copy_pending <= 1'b0;
        end
    end

    // copy sequencer, one byte per clock
    always_ff @(posedge clk)
    begin
        if (srst)
        begin
            state    <= CSBIC_IDLE;
            copy_idx <= 6'h00;
        end
        else
        begin
            unique case (state)
                CSBIC_IDLE:
                begin
                    copy_idx <= 6'h00;
                    if (copy_pending && !copy_dis && frame_start && in_window)
                        state <= CSBIC_COPY;
                end
                CSBIC_COPY:
                begin
                    if (copy_dis || copy_end)
                        state <= CSBIC_IDLE;
                    copy_idx <= copy_idx + 6'h01;
                end
            endcase
        end
    end

    // host buffer, locked out while copying
    always_ff @(posedge clk)
    begin
        if (req.wr && buf_hit && (state == CSBIC_IDLE))
            host_buf[buf_idx] <= req.wdata;
    end

    // transmit buffer fill and read port
    always_ff @(posedge clk)
    begin
        if ((state == CSBIC_COPY) && !copy_dis)
            tx_buf[copy_idx] <= host_buf[copy_idx];
        if (srst)
            tx_cs_data <= 8'h00;
        else
            tx_cs_data <= (tx_cs_addr <= BUF_LAST_IDX) ? tx_buf[tx_cs_addr] : 8'h00;
    end

    // register read data
    always_ff @(posedge clk)
    begin
        if (srst)
            rdata <= 8'h00;
        else if (req.rd)
        begin
            if (buf_hit)
                rdata <= (state == CSBIC_IDLE) ? host_buf[buf_idx] : 8'h00;
            else
                unique case (req.addr)
                    ADDR_MONO_CTRL: rdata <= mono_ctrl;
                    ADDR_IRQ_STAT:  rdata <= irq_stat;
                    ADDR_IRQ_MASK:  rdata <= irq_mask;
                    ADDR_COPY_CTRL: rdata <= copy_ctrl;
                    default:        rdata <= 8'h00;
                endcase
        end
    end

    // mono selection from register or pins
    always_ff @(posedge clk)
    begin
        if (srst)
        begin
            mono_active <= 1'b0;
            audio_right <= 1'b0;
            cs_chan_b   <= 1'b0;
        end
        else if (sw_mode)
        begin
            mono_active <= mono_ctrl[MONO_EN_BIT];
            audio_right <= mono_ctrl[MONO_SRC_BIT];
            cs_chan_b   <= mono_ctrl[MONO_CS_BIT];
        end
        else
        begin
            mono_active <= mono_pin;
            audio_right <= source_pin;
            cs_chan_b   <= source_pin;
        end
    end

    // subframe assembly, mono pairs consecutive samples
    assign sel_right  = audio_right;
    assign sel_sample = sel_right ? right_sample : left_sample;
    always_ff @(posedge clk)
    begin
        if (srst)
        begin
            half         <= 1'b0;
            first_sample <= '0;
            frame_out    <= '0;
            frame_valid  <= 1'b0;
        end
        else
        begin
            frame_valid <= 1'b0;
            if (sample_valid && !mono_active)
            begin
                half        <= 1'b0;
                frame_out   <= '{sub_a: left_sample, sub_b: right_sample};
                frame_valid <= 1'b1;
            end
            else if (sample_valid)
            begin
                half <= !half;
                if (!half)
                    first_sample <= sel_sample;
                else
                begin
                    frame_out   <= '{sub_a: first_sample, sub_b: sel_sample};
                    frame_valid <= 1'b1;
                end
            end
        end
    end

    // checks on the guarded logic
    property p_copy_start;
        @(posedge clk) disable iff (srst)
        (state == CSBIC_IDLE) ##1 (state == CSBIC_COPY)
            |-> $past(frame_start) && $past(frame_num) >= COPY_FRAME_FIRST
                && $past(frame_num) <= COPY_FRAME_LAST;
    endproperty
    a_copy_start: assert property (p_copy_start) else $error("copy began outside window");
    property p_first_frame;
        @(posedge clk) disable iff (srst)
        (copy_pending && !copy_dis && frame_start && in_window && state == CSBIC_IDLE)
            |=> (state == CSBIC_COPY);
    endproperty
    a_first_frame: assert property (p_first_frame) else $error("eligible frame skipped");
    property p_done_flag;
        @(posedge clk) disable iff (srst)
        (copy_end && sw_mode) |=> irq_stat[FLAG_COPY_DONE];
    endproperty
    a_done_flag: assert property (p_done_flag) else $error("copy done flag missing");
    property p_abort;
        @(posedge clk) disable iff (srst)
        (state == CSBIC_COPY && copy_dis) |=> (state == CSBIC_IDLE) [*2];
    endproperty
    a_abort: assert property (p_abort) else $error("copy not aborted");
    property p_hw_quiet;
        @(posedge clk) disable iff (srst)
        (!sw_mode && !stat_read) |=> $stable(irq_stat);
    endproperty
    a_hw_quiet: assert property (p_hw_quiet) else $error("status changed in pin mode");
    property p_flag_hold;
        @(posedge clk) disable iff (srst)
        (irq_stat[FLAG_SLIP_BLK] && !stat_read) |=> irq_stat[FLAG_SLIP_BLK];
    endproperty
    a_flag_hold: assert property (p_flag_hold) else $error("flag dropped without read");
    property p_read_clear;
        @(posedge clk) disable iff (srst)
        (stat_read && next_events == 8'h00) |=> (irq_stat == 8'h00) && !int_n_oe;
    endproperty
    a_read_clear: assert property (p_read_clear) else $error("status read did not clear");
    property p_slip;
        @(posedge clk) disable iff (srst)
        (sw_mode && slip_event && !irq_mask[MASK_SLIP_BLOCKSTART_SELECT_BIT] && !irq_mask[FLAG_SLIP_BLK])
            |=> irq_stat[FLAG_SLIP_BLK] && int_n_oe;
    endproperty
    a_slip: assert property (p_slip) else $error("slip not flagged");
    property p_set_wins;
        @(posedge clk) disable iff (srst)
        (stat_read && sw_mode && aux_event) |=> irq_stat[FLAG_AUX];
    endproperty
    a_set_wins: assert property (p_set_wins) else $error("event lost on read");
    property p_hw_mono;
        @(posedge clk) disable iff (srst)
        !sw_mode |=> (mono_active == $past(mono_pin)) && (cs_chan_b == $past(source_pin));
    endproperty
    a_hw_mono: assert property (p_hw_mono) else $error("pin mode select wrong");
    c_copy_done: cover property (@(posedge clk) disable iff (srst) copy_end);
    c_abort: cover property (@(posedge clk) disable iff (srst) state == CSBIC_COPY && copy_dis);
    c_int: cover property (@(posedge clk) disable iff (srst) int_n_oe ##1 stat_read);
    c_mono: cover property (@(posedge clk) disable iff (srst) mono_active && frame_valid);
endmodule : csbic_top

// File: tb/csbic_host.sv
// host model: control-port register accesses and the pulled-up interrupt line
`timescale 1ns/1ps
module csbic_host
    import csbic_pkg::*;
(
    // clock
    input  wire logic       clk,
    // control port
    output csbic_req_t      req,
    input  wire logic [7:0] rdata,
    // open-drain interrupt
    input  wire logic       int_n_out,
    input  wire logic       int_n_oe,
    output logic            int_line
);
    // pull-up wins whenever the pin is released
    assign int_line = int_n_oe ? int_n_out : 1'b1; // pulled high
    initial req = '0;
    // one-cycle register write
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk);
        #1;
        req = '{addr: a, wr: 1'b1, rd: 1'b0, wdata: d};
        @(posedge clk);
        #1;
        req.wr = 1'b0;
    endtask : wr
    // one-cycle read; status read clears flags
    task automatic rd(input logic [7:0] a, output logic [7:0] d);
        @(posedge clk);
        #1;
        req = '{addr: a, wr: 1'b0, rd: 1'b1, wdata: 8'h00};
        @(posedge clk);
        #1;
        req.rd = 1'b0;
        d = rdata;
    endtask : rd
endmodule : csbic_host

// File: tb/csbic_top_test.sv
// testbench: copy handoff, interrupt flags and mono selection
`timescale 1ns/1ps
module csbic_top_test
    import csbic_pkg::*;
;
    logic clk, srst, sw_mode, mono_pin, source_pin, frame_start, sample_valid;
    logic [7:0] frame_num, rdata, tx_cs_data;
    logic [3:0] ev;
    logic [5:0] tx_cs_addr;
    logic [SAMPLE_W-1:0] left_sample, right_sample;
    csbic_req_t req;
    csbic_frame_t frame_out;
    logic frame_valid, mono_active, audio_right, cs_chan_b, int_n_out, int_n_oe, int_line;
    int err_total, check_count, cyc;

    csbic_top DUT (.clk(clk), .srst(srst), .req(req), .rdata(rdata), .sw_mode(sw_mode),
        .mono_pin(mono_pin), .source_pin(source_pin), .frame_start(frame_start),
        .frame_num(frame_num), .slip_event(ev[0]), .block_start_int(ev[1]),
        .block_start_io(ev[2]), .aux_event(ev[3]), .tx_cs_addr(tx_cs_addr),
        .tx_cs_data(tx_cs_data), .sample_valid(sample_valid), .left_sample(left_sample),
        .right_sample(right_sample), .frame_out(frame_out), .frame_valid(frame_valid),
        .mono_active(mono_active), .audio_right(audio_right), .cs_chan_b(cs_chan_b),
        .int_n_out(int_n_out), .int_n_oe(int_n_oe));
    csbic_host u_host (.clk(clk), .req(req), .rdata(rdata), .int_n_out(int_n_out),
        .int_n_oe(int_n_oe), .int_line(int_line));

    // clock
    initial
    begin
        clk = 1'b0;
        forever #25 clk = ~clk;
    end
    // hang guard
    always @(posedge clk)
    begin
        cyc <= cyc + 1;
        if (cyc == 5000)
        begin
            err_total = err_total + 1;
            stop_test();
        end
    end

    task automatic stop_test();
        if (err_total == 0 && check_count > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask : stop_test
    task automatic chk(input logic [63:0] seen, input logic [63:0] exp);
        check_count = check_count + 1;
        if (seen !== exp)
        begin
            err_total = err_total + 1;
            $display("wrong value at %0t: got %h expected %h", $time, seen, exp);
        end
    endtask : chk
    task automatic rd_chk(input logic [7:0] a, input logic [7:0] exp);
        logic [7:0] v;
        u_host.rd(a, v);
        chk(v, exp);
    endtask : rd_chk
    task automatic cycles(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask : cycles
    task automatic pulse(input int i);
        @(posedge clk);
        #1;
        ev[i] = 1'b1;
        @(posedge clk);
        #1;
        ev[i] = 1'b0;
    endtask : pulse
    task automatic frame(input logic [7:0] n);
        @(posedge clk);
        #1;
        frame_start = 1'b1;
        frame_num = n;
        @(posedge clk);
        #1;
        frame_start = 1'b0;
    endtask : frame
    task automatic sample(input logic [SAMPLE_W-1:0] l, input logic [SAMPLE_W-1:0] r);
        @(posedge clk);
        #1;
        sample_valid = 1'b1;
        left_sample = l;
        right_sample = r;
        @(posedge clk);
        #1;
        sample_valid = 1'b0;
    endtask : sample
    task automatic tx_chk(input logic [5:0] i, input logic [7:0] exp);
        tx_cs_addr = i;
        cycles(1);
        chk(tx_cs_data, exp);
    endtask : tx_chk

    // flags, mask, select and status clear
    task automatic t_events();
        logic [7:0] v;
        rd_chk(ADDR_MONO_CTRL, RST_MONO_CTRL);
        rd_chk(ADDR_IRQ_MASK, RST_IRQ_MASK);
        rd_chk(ADDR_COPY_CTRL, RST_COPY_CTRL); // copy-disable rests at zero
        chk(int_line, 1'b1); // released after reset
        pulse(0);
        chk(int_line, 1'b0); // slip drives pin low
        rd_chk(ADDR_IRQ_STAT, 8'h02); // slip flag
        chk(int_line, 1'b1); // read releases pin
        rd_chk(ADDR_IRQ_STAT, 8'h00); // all flags cleared
        fork
            u_host.rd(ADDR_IRQ_STAT, v);
            pulse(0);
        join
        chk(int_line, 1'b0); // event in read cycle kept
        rd_chk(ADDR_IRQ_STAT, 8'h02);
        u_host.wr(ADDR_IRQ_MASK, 8'h80);
        pulse(0);
        rd_chk(ADDR_IRQ_STAT, 8'h00); // slip not reported in block mode
        pulse(1);
        rd_chk(ADDR_IRQ_STAT, 8'h02); // internal block start
        pulse(2);
        rd_chk(ADDR_IRQ_STAT, 8'h02); // external block start
        u_host.wr(ADDR_IRQ_MASK, 8'h82);
        pulse(2);
        chk(int_line, 1'b1); // masked source keeps pin high
        pulse(3);
        chk(int_line, 1'b0); // third source unmasked
        rd_chk(ADDR_IRQ_STAT, 8'h06); // masked flag still set
        rd_chk(ADDR_IRQ_MASK, 8'h82);
        u_host.wr(ADDR_IRQ_MASK, 8'h00);
    endtask : t_events
    // copy window, discard during copy, abort
    task automatic t_copy();
        u_host.wr(ADDR_COPY_CTRL, 8'h01); // hold off copies
        u_host.wr(ADDR_BUF_FIRST, 8'hA5);
        u_host.wr(ADDR_BUF_LAST, 8'h3C);
        u_host.wr(ADDR_COPY_CTRL, 8'h00);
        frame(8'hB7);
        cycles(60);
        rd_chk(ADDR_IRQ_STAT, 8'h00); // no copy before frame 184
        frame(COPY_FRAME_FIRST);
        rd_chk(ADDR_BUF_FIRST, 8'h00); // read refused mid-copy
        u_host.wr(ADDR_BUF_FIRST, 8'hFF);
        cycles(60);
        chk(int_line, 1'b0); // done drives pin low
        rd_chk(ADDR_IRQ_STAT, 8'h01); // done flag
        tx_chk(6'h00, 8'hA5); // first byte moved
        tx_chk(BUF_LAST_IDX, 8'h3C); // last byte moved
        rd_chk(ADDR_BUF_FIRST, 8'hA5); // write mid-copy dropped
        u_host.wr(ADDR_COPY_CTRL, 8'h01);
        u_host.wr(ADDR_BUF_FIRST, 8'h5A);
        u_host.wr(ADDR_BUF_LAST, 8'hC3);
        u_host.wr(ADDR_COPY_CTRL, 8'h00);
        frame(COPY_FRAME_LAST);
        u_host.wr(ADDR_COPY_CTRL, 8'h01); // stop the copy
        cycles(60);
        rd_chk(ADDR_IRQ_STAT, 8'h00); // no done after abort
        tx_chk(6'h00, 8'h5A); // early byte kept
        tx_chk(BUF_LAST_IDX, 8'h3C); // late byte untouched
    endtask : t_copy
    // software and pin mono selection
    task automatic t_mono();
        u_host.wr(ADDR_MONO_CTRL, 8'h05);
        cycles(1);
        chk({mono_active, audio_right, cs_chan_b}, 3'b101); // status source alone
        u_host.wr(ADDR_MONO_CTRL, 8'h07);
        cycles(1);
        chk({mono_active, audio_right, cs_chan_b}, 3'b111);
        sample(24'h111111, 24'h222222);
        sample(24'h333333, 24'h444444);
        chk({frame_valid, frame_out}, {1'b1, 48'h222222_444444});
        u_host.wr(ADDR_MONO_CTRL, 8'h00);
        sample(24'h555555, 24'h666666);
        chk({frame_valid, frame_out}, {1'b1, 48'h555555_666666}); // stereo
        sw_mode = 1'b0;
        mono_pin = 1'b1;
        cycles(2);
        chk({mono_active, audio_right, cs_chan_b}, 3'b100);
        sample(24'hAAAAAA, 24'hBBBBBB);
        sample(24'hCCCCCC, 24'hDDDDDD);
        chk(frame_out, 48'hAAAAAA_CCCCCC); // left source
        source_pin = 1'b1;
        cycles(2);
        chk({mono_active, audio_right, cs_chan_b}, 3'b111);
        pulse(0);
        chk(int_line, 1'b1); // no interrupts in pin mode
        mono_pin = 1'b0;
        cycles(2);
        chk(mono_active, 1'b0); // stereo when low
        sw_mode = 1'b1;
    endtask : t_mono

    // main sequence
    initial
    begin
        {srst, sw_mode, mono_pin, source_pin, frame_start, sample_valid} = 6'b110000;
        {frame_num, ev, tx_cs_addr, left_sample, right_sample} = '0;
        {err_total, check_count, cyc} = '0;
        repeat (4) @(posedge clk);
        #1;
        srst = 1'b0;
        t_events();
        t_copy();
        t_mono();
        stop_test();
    end
endmodule : csbic_top_test
